// [rtl/fab_hist_mem.sv]
// small memory holding the last words read back from the flash
`timescale 1ns/100ps
module fab_hist_mem
    import fab_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_W,
    parameter int unsigned DEPTH = HIST_DEPTH,
    parameter int unsigned AW    = HIST_AW
) (
    input  wire logic             i_clk,
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    // ---------------------------------------------------------------
    // storage and registered read port
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_q[i_raddr];
    end
endmodule

// [rtl/fab_host.sv]
// host controller driving the flash asynchronous parallel bus
// How it works
// - host holds reset low at power-up
// - never oe and we low together
// - read keeps we and reset high
// - host gives proper address per command
`timescale 1ns/100ps
module fab_host
    import fab_pkg::*;
#(
    parameter int unsigned RST_CYC = RST_LOW_CYC
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    // user side
    input  wire logic              i_req,
    input  wire logic              i_wr,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_byte_mode,
    input  wire logic [HIST_AW-1:0] i_hist_sel,
    output logic                   o_ready,
    output logic                   o_done,
    output logic      [DATA_W-1:0] o_rdata,
    output logic      [DATA_W-1:0] o_hist_data,
    output logic                   o_busy,
    // flash pins
    output logic                   o_reset_powerdown_n,
    output logic                   o_chip_select_zero,
    output logic                   o_chip_select_one,
    output logic                   o_chip_select_two,
    output logic                   o_oe_n,
    output logic                   o_we_n,
    output logic      [ADDR_W-1:0] o_addr,
    output logic                   o_byte_n,
    output logic      [DATA_W-1:0] o_data_out,
    output logic                   o_data_oe,
    input  wire logic [DATA_W-1:0] i_data_in,
    input  wire logic              i_ready_busy_out
);
    fab_state_e        st_q, st_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic [2:0]        cs_q, cs_d;
    logic              oe_n_q, oe_n_d, we_n_q, we_n_d, rp_q, rp_d;
    logic              doe_q, doe_d, done_q, done_d, byte_q, byte_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
    logic [HIST_AW-1:0] hp_q, hp_d;
    logic              hist_we;

    // ---------------------------------------------------------------
    // bus sequencer
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q; cnt_d = cnt_q; cs_d = cs_q; oe_n_d = oe_n_q;
        we_n_d = we_n_q; rp_d = rp_q; doe_d = doe_q; done_d = 1'b0;
        byte_d = byte_q; addr_d = addr_q; wd_d = wd_q; rd_d = rd_q;
        hp_d = hp_q; hist_we = 1'b0;
        case (st_q)
            FAB_RST: begin
                rp_d = 1'b0;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= CNT_W'(RST_CYC - 1)) begin
                    rp_d = 1'b1; cnt_d = '0; st_d = FAB_WAKE;
                end
            end
            FAB_WAKE: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= CNT_W'(WAKE_CYC - 1)) begin
                    cnt_d = '0; st_d = FAB_IDLE;
                end
            end
            FAB_IDLE: begin
                if (i_req) begin
                    addr_d = i_addr;
                    byte_d = i_byte_mode;
                    // byte mode only carries the low lane
                    wd_d = i_byte_mode ? (i_wdata & DATA_W'(BYTE_MASK))
                                       : i_wdata;
                    cs_d = CS_SELECT;
                    cnt_d = '0;
                    if (i_wr) begin
                        we_n_d = 1'b0; oe_n_d = 1'b1;
                        doe_d = 1'b1; st_d = FAB_WR;
                    end else begin
                        oe_n_d = 1'b0; we_n_d = 1'b1;
                        doe_d = 1'b0; st_d = FAB_RD;
                    end
                end
            end
            FAB_RD: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= CNT_W'(ACC_CYC - 1)) begin
                    // busy status leaves only bit 7 valid
                    if (!i_ready_busy_out) begin
                        rd_d = '0;
                        rd_d[BUSY_BIT] = i_data_in[BUSY_BIT];
                    end else if (byte_q) begin
                        rd_d = i_data_in & DATA_W'(BYTE_MASK);
                    end else begin
                        rd_d = i_data_in;
                    end
                    hist_we = 1'b1;
                    hp_d = hp_q + 1'b1;
                    oe_n_d = 1'b1; cs_d = CS_DESELECT;
                    done_d = 1'b1; cnt_d = '0; st_d = FAB_REC;
                end
            end
            FAB_WR: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= CNT_W'(WP_CYC - 1)) begin
                    we_n_d = 1'b1;
                    cnt_d = '0; st_d = FAB_REC;
                end
            end
            FAB_REC: begin
                // deselect one cycle after we rise; hold data one gap past we rise
                if (cnt_q == '0) begin
                    cs_d = CS_DESELECT;
                end
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= CNT_W'(GAP_CYC - 1)) begin
                    if (doe_q) done_d = 1'b1;
                    doe_d = 1'b0; cnt_d = '0; st_d = FAB_IDLE;
                end
            end
            default: st_d = FAB_RST;
        endcase
    end

    // ---------------------------------------------------------------
    // registers; reset re-runs the power-on sequence
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_q <= FAB_RST; cnt_q <= '0; cs_q <= CS_DESELECT;
            oe_n_q <= 1'b1; we_n_q <= 1'b1; rp_q <= 1'b0;
            doe_q <= 1'b0; done_q <= 1'b0; byte_q <= 1'b0;
            addr_q <= '0; wd_q <= '0; rd_q <= '0; hp_q <= '0;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d; cs_q <= cs_d;
            oe_n_q <= oe_n_d; we_n_q <= we_n_d; rp_q <= rp_d;
            doe_q <= doe_d; done_q <= done_d; byte_q <= byte_d;
            addr_q <= addr_d; wd_q <= wd_d; rd_q <= rd_d; hp_q <= hp_d;
        end
    end

    // ---------------------------------------------------------------
    // read history
    // ---------------------------------------------------------------
    fab_hist_mem u_hist (
        .i_clk   (i_clk),
        .i_we    (hist_we),
        .i_waddr (hp_q),
        .i_wdata (rd_d),
        .i_raddr (i_hist_sel),
        .o_rdata (o_hist_data)
    );

    // pins; busy line is an open drain pulled high outside
    assign o_reset_powerdown_n = rp_q;
    assign o_chip_select_zero  = cs_q[0];
    assign o_chip_select_one   = cs_q[1];
    assign o_chip_select_two   = cs_q[2];
    assign o_oe_n              = oe_n_q;
    assign o_we_n              = we_n_q;
    assign o_addr              = addr_q;
    assign o_byte_n            = ~byte_q;
    assign o_data_out          = wd_q;
    assign o_data_oe           = doe_q;
    assign o_ready             = (st_q == FAB_IDLE);
    assign o_done              = done_q;
    assign o_rdata             = rd_q;
    assign o_busy              = ~i_ready_busy_out;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // write strobe low for the whole pulse width
    sequence s_wr_pulse;
        !o_we_n [*7];
    endsequence
    // we rises while still selected, deselect follows one cycle later
    sequence s_cs_release;
        !o_chip_select_zero ##1 o_chip_select_zero;
    endsequence
    no_oe_we_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        !(!o_oe_n && !o_we_n))
        else $error("oe and we low together");
    rd_ctl_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        !o_oe_n |-> o_we_n && o_reset_powerdown_n
                    && o_chip_select_zero == 1'b0)
        else $error("read control wrong");
    wr_ctl_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        $fell(o_we_n) |-> (o_oe_n && o_data_oe) ##0 s_wr_pulse ##1 o_we_n)
        else $error("write pulse wrong");
    wr_latch_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_we_n) |-> s_cs_release)
        else $error("we must rise before cs");
    // eight cycles is only a floor, so RST_CYC below 8 trips it
    rst_hold_a: assert property (
        @(posedge i_clk)
        !i_rst_b ##1 i_rst_b |-> !o_reset_powerdown_n [*8])
        else $error("reset pulse too short");
    wake_wait_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_reset_powerdown_n) |-> !o_ready [*8])
        else $error("access before wake-up");
    byte_lane_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        o_data_oe && !o_byte_n |-> o_data_out[15:8] == 8'h00)
        else $error("byte mode high lane used");
    // a read that ended while the flash was busy keeps only bit 7
    busy_rd_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        o_done && o_oe_n && !$past(o_oe_n) && !$past(i_ready_busy_out)
        |-> o_rdata[15:8] == 8'h00 && o_rdata[6:0] == 7'h00)
        else $error("busy read wider");
endmodule

// [shared/fab_pkg.sv]
// constants for the flash async bus host controller
package fab_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned RST_LOW_US       = 35;    // reset pulse low
    localparam int unsigned RST_LOW_CYC      =
        (RST_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_NS          = 150;   // wake-up interval
    localparam int unsigned WAKE_CYC         =
        (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACC_NS           = 120;   // read access
    localparam int unsigned ACC_CYC          =
        (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WP_NS            = 70;    // write pulse
    localparam int unsigned WP_CYC           =
        (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GAP_CYC          = 2;     // recovery / data hold
    localparam int unsigned CNT_W            = 16;
    // ---------------------------------------------------------------
    // chip select pattern driven for selection / deselection
    // ---------------------------------------------------------------
    localparam logic [2:0]  CS_SELECT        = 3'h0;
    localparam logic [2:0]  CS_DESELECT      = 3'h7;
    localparam int unsigned DATA_W           = 16;
    localparam int unsigned ADDR_W           = 24;
    localparam logic [7:0]  BYTE_MASK        = 8'hff;
    localparam int unsigned BUSY_BIT         = 7;
    localparam int unsigned HIST_DEPTH       = 4;
    localparam int unsigned HIST_AW          = 2;
    typedef enum logic [2:0] {
        FAB_RST, FAB_WAKE, FAB_IDLE, FAB_RD, FAB_WR, FAB_REC
    } fab_state_e;
endpackage

// [verification/fab_flash_model.sv]
// behavioural flash device model facing the host pins
`timescale 1ns/100ps
module fab_flash_model
    import fab_pkg::*;
#(
    parameter int unsigned BUSY_CYC = 40
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_powerdown_n,
    input  wire logic              i_chip_select_zero,
    input  wire logic              i_chip_select_one,
    input  wire logic              i_chip_select_two,
    input  wire logic              i_oe_n,
    input  wire logic              i_we_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_byte_n,
    input  wire logic [DATA_W-1:0] i_data,
    input  wire logic              i_program_enable_supply,
    output logic      [DATA_W-1:0] o_data,
    output logic                   o_ready_busy_out
);
    // ----------------------------------------------------------
    // storage and bus decode
    // ----------------------------------------------------------
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] val, msk;
    logic [DATA_W-1:0] last = '0;
    logic [1:0]        mode = 2'h0; // 0 array, 1 status, 2 setup
    int                busy = 0, wake = 0, tgt = 0;
    logic              sel, wr_act, drv;
    // two high with one and zero not both high also selects
    assign sel = (!i_chip_select_two && !i_chip_select_one &&
        !i_chip_select_zero) || (i_chip_select_two &&
        !(i_chip_select_one && i_chip_select_zero));
    assign wr_act = i_reset_powerdown_n && sel && !i_we_n &&
        i_oe_n;
    assign drv = i_reset_powerdown_n && sel && !i_oe_n && i_we_n &&
        wake == 0;
    // read value and which lines are driven
    always @* begin
        if (mode != 2'h0) val = {8'h00, busy == 0, 7'h00};
        else if (mem.exists(i_addr)) val = mem[i_addr];
        else val = i_addr[15:0] ^ 16'ha5c3;
        if (!drv) msk = 16'h0000;
        else if (mode != 2'h0 && busy != 0) msk = 16'h0080;
        else msk = i_byte_n ? 16'hffff : 16'h00ff;
    end
    // floating lines flip each cycle, so no stale value reads back
    assign o_data = (val & msk) | (~last & ~msk);
    assign o_ready_busy_out = !i_reset_powerdown_n || busy == 0;
    // first of we rise or deselect closes the write, any address
    always @(negedge wr_act) begin
        if (i_reset_powerdown_n) begin
            if (mode == 2'h2) begin
                if (i_program_enable_supply) begin
                    mem[i_addr] = i_data;
                    tgt = i_addr;
                    busy = BUSY_CYC;
                end
                mode = 2'h1;
            end
            else if (i_data[7:0] == 8'h40) mode = 2'h2;
            else if (i_data[7:0] == 8'h70) mode = 2'h1;
            else if (i_data[7:0] == 8'hff) mode = 2'h0;
        end
    end
    // reset aborts and corrupts; deselect does not stop the work;
    // state moves on the falling edge so host samples never race it
    always @(negedge i_clk) begin
        last <= o_data;
        if (!i_reset_powerdown_n) begin
            if (busy != 0) mem[tgt] = ~mem[tgt];
            busy = 0;
            mode = 2'h0;
            wake = WAKE_CYC;
        end else begin
            if (busy != 0) busy = busy - 1;
            if (wake != 0) wake = wake - 1;
        end
    end
endmodule

// [verification/tb_top.sv]
// self-checking bench for the flash bus host controller
`timescale 1ns/100ps
module tb_top
    import fab_pkg::*;
    ;
    localparam int unsigned RCYC = 8;
    logic clk = 1'b0, rst_b = 1'b0, req = 1'b0, wr = 1'b0;
    logic bmode = 1'b0, program_enable_supply = 1'b1;
    logic [ADDR_W-1:0] addr = '0, fa;
    logic [DATA_W-1:0] wdata = '0, rdata, dout, fdat, dq, hist;
    logic [HIST_AW-1:0] hsel = '0;
    logic rdy, done, busy, rp_n, cs0, cs1, cs2, oe_n, we_n, bn, doe, rb;
    int error_cnt = 0, n_compared = 0;
    // ----------------------------------------------------------
    // design, device model and shared data lines
    // ----------------------------------------------------------
    assign dq = doe ? dout : fdat;
    fab_host #(.RST_CYC(RCYC)) fab_host_inst (.i_clk(clk),
        .i_rst_b(rst_b), .i_req(req), .i_wr(wr), .i_addr(addr),
        .i_wdata(wdata), .i_byte_mode(bmode), .i_hist_sel(hsel),
        .o_ready(rdy), .o_done(done), .o_rdata(rdata), .o_hist_data(hist),
        .o_busy(busy), .o_reset_powerdown_n(rp_n),
        .o_chip_select_zero(cs0), .o_chip_select_one(cs1),
        .o_chip_select_two(cs2), .o_oe_n(oe_n), .o_we_n(we_n),
        .o_addr(fa), .o_byte_n(bn), .o_data_out(dout),
        .o_data_oe(doe), .i_data_in(dq), .i_ready_busy_out(rb));
    fab_flash_model fab_flash_model_inst (.i_clk(clk),
        .i_reset_powerdown_n(rp_n), .i_chip_select_zero(cs0),
        .i_chip_select_one(cs1), .i_chip_select_two(cs2),
        .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(fa), .i_byte_n(bn),
        .i_data(dq), .i_program_enable_supply(program_enable_supply), .o_data(fdat),
        .o_ready_busy_out(rb));
    initial forever #5 clk = ~clk;
    // ----------------------------------------------------------
    // shared tasks, all entered and left at a falling edge except the first do_reset, entered at time 0
    // ----------------------------------------------------------
    function automatic logic [15:0] pat(input logic [23:0] a);
        return a[15:0] ^ 16'ha5c3;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one bus request; waits are bounded so a hang cannot stall
    task automatic xfer(input logic w, input logic [23:0] a,
                        input logic [15:0] d);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        req = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge clk);
        req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        chk(16'(n < 100), 16'h1);
    endtask
    task automatic do_reset();
        int n;
        rst_b = 1'b0;
        repeat (12) @(negedge clk);
        chk({rp_n, cs2, cs1, cs0, oe_n, we_n, doe, rdy}, 16'h7c);
        rst_b = 1'b1;
        n = 0;
        while (rdy !== 1'b1 && n < 500) begin @(negedge clk); n++; end
        chk(16'(n), 16'(RCYC + WAKE_CYC));
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_read();
        logic [23:0] al [3] = '{24'h000000, 24'h00ffff, 24'hfedcba};
        foreach (al[i]) begin
            xfer(1'b0, al[i], 16'h0);
            chk(rdata, pat(al[i]));
        end
        bmode = 1'b1;
        xfer(1'b0, 24'h000abc, 16'h0);
        chk(rdata, pat(24'h000abc) & 16'h00ff);
        chk({15'h0, bn}, 16'h0);
        // high byte must be dropped; low byte is the array read command
        xfer(1'b1, 24'h000000, 16'h12ff);
        bmode = 1'b0;
        xfer(1'b0, 24'h00ffff, 16'h0);
        chk(rdata, pat(24'h00ffff));
    endtask
    // history port returns earlier reads one clock after the select
    task automatic t_hist();
        hsel = 2'h3;
        @(negedge clk);
        chk(hist, pat(24'h000abc) & 16'h00ff);
        hsel = 2'h0;
        @(negedge clk);
        chk(hist, pat(24'h00ffff));
    endtask
    task automatic t_prog();
        int n;
        xfer(1'b1, 24'h7a0001, 16'h0040);
        xfer(1'b1, 24'h123456, 16'hbeef);
        xfer(1'b0, 24'h000000, 16'h0);
        chk(rdata, 16'h0000);
        chk({15'h0, busy}, 16'h1);
        n = 0;
        while (busy !== 1'b0 && n < 200) begin @(negedge clk); n++; end
        chk(16'(n < 200), 16'h1);
        xfer(1'b0, 24'h000000, 16'h0);
        chk(rdata, 16'h0080);
        xfer(1'b1, 24'h000000, 16'h00ff);
        xfer(1'b0, 24'h123456, 16'h0);
        chk(rdata, 16'hbeef);
    endtask
    task automatic t_lock();
        program_enable_supply = 1'b0;
        xfer(1'b1, 24'h000222, 16'h0040);
        xfer(1'b1, 24'h000222, 16'h2222);
        chk({15'h0, busy}, 16'h0);
        xfer(1'b1, 24'h000000, 16'h00ff);
        xfer(1'b0, 24'h000222, 16'h0);
        chk(rdata, pat(24'h000222));
        program_enable_supply = 1'b1;
    endtask
    task automatic t_abort();
        xfer(1'b1, 24'h000333, 16'h0040);
        xfer(1'b1, 24'h000333, 16'h1111);
        do_reset();
        chk({15'h0, busy}, 16'h0);
        // status mode before reset; reset alone must restore array reads
        xfer(1'b0, 24'h000abc, 16'h0);
        chk(rdata, pat(24'h000abc));
        xfer(1'b1, 24'h000000, 16'h0070);
        xfer(1'b0, 24'h000000, 16'h0);
        chk(rdata, 16'h0080);
        xfer(1'b1, 24'h000000, 16'h00ff);
        xfer(1'b0, 24'h000333, 16'h0);
        chk(16'(rdata === 16'h1111), 16'h0);
    endtask
    task automatic end_of_test();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        do_reset();
        t_read();
        t_hist();
        t_prog();
        t_lock();
        t_abort();
        end_of_test();
    end
    // watchdog well past the expected few hundred cycles
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule
